/* pic_top.sv */
// Pulse interval capture channel with APB registers and interrupt
`timescale 1ns/100ps
`default_nettype none
module pic_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pic_pkg::PIC_ADDR_W-1:0] paddr,
  input wire logic [pic_pkg::PIC_DATA_W-1:0] pwdata,
  output logic [pic_pkg::PIC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pin
  input wire logic capture_input_pin,
  // Interrupt
  output logic capture_done_irq
);
  import pic_pkg::*;

  pic_chan_if chan();

  // Word decode of one register offset
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr[7:2] == off[7:2]);
  endfunction

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic start_q;
  logic stop_q;
  pic_edge_type edge_sel_q;
  logic clksel_q;
  logic [3:0] div_q;
  logic [15:0] div_cnt_q;
  logic [1:0] sts_q;
  logic [1:0] sts_d;
  logic [1:0] en_q;
  logic irq_q;

  // APB phases
  wire access_w = psel & penable & ~pready_q;
  wire done_w = psel & penable & pready_q;
  wire wr_w = done_w & pwrite;

  wire sel_ctrl_w = addr_hit(paddr, PIC_CTRL_OFF);
  wire sel_cfg_w = addr_hit(paddr, PIC_CFG_OFF);
  wire sel_count_w = addr_hit(paddr, PIC_COUNT_OFF);
  wire sel_cap_w = addr_hit(paddr, PIC_CAPTURE_OFF);
  wire sel_sts_w = addr_hit(paddr, PIC_IRQ_STATUS_OFF);
  wire sel_clr_w = addr_hit(paddr, PIC_IRQ_CLEAR_OFF);
  wire sel_en_w = addr_hit(paddr, PIC_IRQ_ENABLE_OFF);
  wire mapped_w = sel_ctrl_w | sel_cfg_w | sel_count_w | sel_cap_w | sel_sts_w | sel_clr_w | sel_en_w;

  // Command strobes
  wire start_w = wr_w & sel_ctrl_w & pwdata[PIC_CTRL_START_BIT];
  wire stop_w = wr_w & sel_ctrl_w & pwdata[PIC_CTRL_STOP_BIT];

  // Read-back views
  wire [31:0] ctrl_rd_w = {30'h0, chan.cap_valid, chan.running};
  wire [31:0] cfg_rd_w = {24'h0, div_q, 1'b0, clksel_q, edge_sel_q};
  wire [31:0] rd_mux_w = sel_ctrl_w ? ctrl_rd_w :
                         sel_cfg_w ? cfg_rd_w :
                         sel_count_w ? {16'h0, chan.count} :
                         sel_cap_w ? {16'h0, chan.capture} :
                         sel_sts_w ? {30'h0, sts_q} :
                         sel_en_w ? {30'h0, en_q} : 32'h0;

  // Operation clock select: undivided pclk or a power-of-two division
  wire [15:0] div_mask_w = 16'((17'h1 << div_q) - 17'h1);
  wire tick_w = ~clksel_q | ((div_cnt_q & div_mask_w) == div_mask_w);

  // Sticky event sources
  wire [1:0] set_w = {chan.wrap_pulse, chan.cap_pulse};
  wire [1:0] clr_w = (wr_w & sel_clr_w) ? pwdata[1:0] : 2'h0;

  genvar gi;
  generate
    for (gi = 0; gi < PIC_IRQ_N; gi++) begin : g_sts
      assign sts_d[gi] = set_w[gi] | (sts_q[gi] & ~clr_w[gi]);
    end
  endgenerate

  assign chan.start = start_q;
  assign chan.stop = stop_q;
  assign chan.tick = tick_w;
  assign chan.edge_sel = edge_sel_q;

  pic_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .capture_input_pin(capture_input_pin),
    .chan(chan.det)
  );

  pic_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .chan(chan.cnt)
  );

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= access_w;
      pslverr_q <= access_w & ~mapped_w;
      prdata_q <= access_w ? rd_mux_w : 32'h0;
    end
  end

  // Start and stop commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      start_q <= start_w;
      stop_q <= stop_w;
    end
  end

  // Configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel_q <= PIC_EDGE_RST;
      clksel_q <= PIC_CLKSEL_RST;
      div_q <= PIC_DIV_RST;
    end else if (wr_w && sel_cfg_w) begin
      edge_sel_q <= pic_edge_type'(pwdata[PIC_CFG_EDGE_LSB +: 2]);
      clksel_q <= pwdata[PIC_CFG_CLKSEL_BIT];
      div_q <= pwdata[PIC_CFG_DIV_LSB +: PIC_DIV_W];
    end
  end

  // Prescaler runs only while counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= PIC_CNT_RST;
    end else if (!chan.running || start_q) begin
      div_cnt_q <= PIC_CNT_RST;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // Interrupt status, enable and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= PIC_IRQ_RST;
      en_q <= PIC_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      if (wr_w && sel_en_w) begin
        en_q <= pwdata[1:0];
      end
      irq_q <= |(sts_q & en_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign capture_done_irq = irq_q;
endmodule
`default_nettype wire

/* pic_pkg.sv */
// Constants, types and register map of the pulse interval capture channel
//
// Overview of operation
// - Writing 1 to the channel start bit enables counting, forces the count to 0000H and starts it.
// - The count advances on the selected operation clock, which by default is the undivided pclk.
// - In capture mode the capture trigger is the detected valid edge of the capture input pin.
// - The valid edge is selectable as falling, rising or both, with rising-edge-only as the default.
// - On each valid edge while counting, unless a start or stop command arrives in the same cycle, the present count is copied into the capture register.
// - In the same cycle as the capture the count is cleared to 0000H, so each capture after the first since start is one interval.
// - Each capture sets the capture-done status; with its enable bit set this raises the interrupt request, a level able to wake a halted processor.
// - Writing 1 to the channel stop bit disables counting; no captures or requests follow.
package pic_pkg;
  localparam int unsigned PIC_ADDR_W = 8;
  localparam int unsigned PIC_DATA_W = 32;
  localparam int unsigned PIC_CNT_W = 16;
  localparam int unsigned PIC_DIV_W = 4;
  localparam int unsigned PIC_IRQ_N = 2;

  localparam logic [7:0] PIC_CTRL_OFF = 8'h00;
  localparam logic [7:0] PIC_CFG_OFF = 8'h04;
  localparam logic [7:0] PIC_COUNT_OFF = 8'h08;
  localparam logic [7:0] PIC_CAPTURE_OFF = 8'h0c;
  localparam logic [7:0] PIC_IRQ_STATUS_OFF = 8'h10;
  localparam logic [7:0] PIC_IRQ_CLEAR_OFF = 8'h14;
  localparam logic [7:0] PIC_IRQ_ENABLE_OFF = 8'h18;

  localparam int unsigned PIC_CTRL_START_BIT = 0;
  localparam int unsigned PIC_CTRL_STOP_BIT = 1;
  localparam int unsigned PIC_CTRL_RUN_BIT = 0;
  localparam int unsigned PIC_CTRL_VALID_BIT = 1;

  localparam int unsigned PIC_CFG_EDGE_LSB = 0;
  localparam int unsigned PIC_CFG_CLKSEL_BIT = 2;
  localparam int unsigned PIC_CFG_DIV_LSB = 4;

  localparam int unsigned PIC_IRQ_CAP_BIT = 0;
  localparam int unsigned PIC_IRQ_WRAP_BIT = 1;

  localparam logic [15:0] PIC_CNT_RST = 16'h0000;
  localparam logic [15:0] PIC_CNT_MAX = 16'hffff;
  localparam logic PIC_CLKSEL_RST = 1'b0;
  localparam logic [3:0] PIC_DIV_RST = 4'h0;
  localparam logic [1:0] PIC_IRQ_RST = 2'h0;

  typedef enum logic [1:0] {
    PIC_EDGE_FALL = 2'h0,
    PIC_EDGE_RISE = 2'h1,
    PIC_EDGE_BOTH = 2'h2,
    PIC_EDGE_NONE = 2'h3
  } pic_edge_type;

  localparam pic_edge_type PIC_EDGE_RST = PIC_EDGE_RISE;

  typedef enum logic [1:0] {
    PIC_ST_IDLE = 2'b01,
    PIC_ST_COUNT = 2'b10
  } pic_state_type;
endpackage

/* pic_chan_if.sv */
// Signals shared by the channel's control, edge detector and counter
`timescale 1ns/100ps
`default_nettype none
interface pic_chan_if;
  import pic_pkg::*;
  logic start;
  logic stop;
  logic tick;
  pic_edge_type edge_sel;
  logic edge_hit;
  logic running;
  logic cap_valid;
  logic cap_pulse;
  logic wrap_pulse;
  logic [15:0] count;
  logic [15:0] capture;
  modport ctl(output start, stop, tick, edge_sel,
    input running, cap_valid, cap_pulse, wrap_pulse, count, capture);
  modport det(input edge_sel, output edge_hit);
  modport cnt(input start, stop, tick, edge_hit,
    output running, cap_valid, cap_pulse, wrap_pulse, count, capture);
endinterface
`default_nettype wire

/* pic_edge_detect.sv */
// Synchroniser and valid-edge detector for the capture input pin
`timescale 1ns/100ps
`default_nettype none
module pic_edge_detect (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin
  input wire logic capture_input_pin,
  // Channel
  pic_chan_if.det chan
);
  import pic_pkg::*;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  wire rise_w = sync2_q & ~prev_q;
  wire fall_w = ~sync2_q & prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= capture_input_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Valid-edge selection
  assign chan.edge_hit = (chan.edge_sel == PIC_EDGE_RISE) ? rise_w :
                         (chan.edge_sel == PIC_EDGE_FALL) ? fall_w :
                         (chan.edge_sel == PIC_EDGE_BOTH) ? (rise_w | fall_w) : 1'b0;
endmodule
`default_nettype wire

/* pic_counter.sv */
// Count, capture and clear logic of the channel
`timescale 1ns/100ps
`default_nettype none
module pic_counter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Channel
  pic_chan_if.cnt chan
);
  import pic_pkg::*;
  pic_state_type state_q, state_d;
  logic [15:0] count_q, count_d;
  logic [15:0] capture_q, capture_d;
  logic cap_pulse_q, cap_pulse_d;
  logic wrap_pulse_q, wrap_pulse_d;
  logic [1:0] seen_q, seen_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    capture_d = capture_q;
    cap_pulse_d = 1'b0;
    wrap_pulse_d = 1'b0;
    seen_d = seen_q;
    unique case (state_q)
      PIC_ST_IDLE: begin
        if (chan.start && !chan.stop) begin
          state_d = PIC_ST_COUNT;
          count_d = PIC_CNT_RST;
          seen_d = 2'h0;
        end
      end
      PIC_ST_COUNT: begin
        if (chan.stop) begin
          state_d = PIC_ST_IDLE;
        end else if (chan.start) begin
          count_d = PIC_CNT_RST;
          seen_d = 2'h0;
        end else if (chan.edge_hit) begin
          capture_d = count_q;
          count_d = PIC_CNT_RST;
          cap_pulse_d = 1'b1;
          seen_d = (seen_q == 2'h2) ? seen_q : seen_q + 2'h1;
        end else if (chan.tick) begin
          count_d = count_q + 16'h0001;
          wrap_pulse_d = (count_q == PIC_CNT_MAX);
        end
      end
      default: begin
        state_d = PIC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PIC_ST_IDLE;
      count_q <= PIC_CNT_RST;
      capture_q <= PIC_CNT_RST;
      cap_pulse_q <= 1'b0;
      wrap_pulse_q <= 1'b0;
      seen_q <= 2'h0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      capture_q <= capture_d;
      cap_pulse_q <= cap_pulse_d;
      wrap_pulse_q <= wrap_pulse_d;
      seen_q <= seen_d;
    end
  end

  assign chan.running = (state_q == PIC_ST_COUNT);
  assign chan.cap_valid = (seen_q == 2'h2);
  assign chan.cap_pulse = cap_pulse_q;
  assign chan.wrap_pulse = wrap_pulse_q;
  assign chan.count = count_q;
  assign chan.capture = capture_q;
endmodule
`default_nettype wire

/* pic_assertions.sv */
// Port checker of the pulse interval capture channel
`timescale 1ns/100ps
`default_nettype none
module pic_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and interrupt
  input wire logic capture_input_pin,
  input wire logic capture_done_irq
);
  import pic_pkg::*;
  logic [7:0] since_start_q, since_evt_q;
  logic [3:0] since_stop_q;
  logic [1:0] en_q;
  logic pin_q;
  wire logic wr_done = psel & penable & pready & pwrite;
  wire logic rd_done = psel & penable & pready & !pwrite;
  wire logic ctl_wr = wr_done && paddr == PIC_CTRL_OFF;
  wire logic en_wr = wr_done && paddr == PIC_IRQ_ENABLE_OFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_start_q <= 8'hff;
      since_evt_q <= 8'hff;
      since_stop_q <= 4'h0;
      en_q <= 2'h0;
      pin_q <= 1'b0;
    end else begin
      since_start_q <= (ctl_wr && pwdata[1:0] == 2'h1) ? 8'h00 : since_start_q + {7'h0, since_start_q != 8'hff};
      since_evt_q <= (en_wr || pin_q != capture_input_pin) ? 8'h00 : since_evt_q + {7'h0, since_evt_q != 8'hff};
      since_stop_q <= ctl_wr ? {3'h0, pwdata[1]} : since_stop_q + {3'h0, since_stop_q inside {[4'h1:4'he]}};
      en_q <= en_wr ? pwdata[1:0] : en_q;
      pin_q <= capture_input_pin;
    end
  end
  property p_access_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  a_access_wait: assert property (p_access_wait) else $error("pready not in second access cycle");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero outside answer");
  property p_err_map; pready |-> pslverr == (paddr[7:2] > 6'h06); endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_count_bound; rd_done && paddr == PIC_COUNT_OFF && since_start_q inside {[8'h04:8'hfe]}
    |-> prdata <= {24'h0, since_start_q}; endproperty
  a_count_bound: assert property (p_count_bound) else $error("count above time since start");
  property p_irq_cause; $rose(capture_done_irq) |-> since_evt_q <= 8'h08; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without pin edge");
  property p_irq_masked; en_q == 2'h0 && $past(en_q) == 2'h0 |-> !capture_done_irq; endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while disabled");
  property p_stop_quiet; since_stop_q == 4'hf |-> !$rose(capture_done_irq); endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("irq after stop");
endmodule
`default_nettype wire

/* pic_pulse_src.sv */
// Periodic pulse source on the capture input pin
`timescale 1ns/100ps
`default_nettype none
module pic_pulse_src (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [15:0] period,
  // Pin
  output logic pin
);
  logic [15:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_q <= 16'h0;
    else if (!run || cnt_q == period - 16'h1)
      cnt_q <= 16'h0;
    else
      cnt_q <= cnt_q + 16'h1;
  end
  // Rise at each period start, high four cycles
  assign pin = run && cnt_q < 16'h4;
endmodule
`default_nettype wire

/* pic_tb.sv */
// Self-checking bench of the pulse interval capture channel
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pic_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, run, pready, pslverr, pin, irq, er, iv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  int fails, comparisons;
  pic_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(pin), .capture_done_irq(irq));
  pic_pulse_src u_src (.pclk(pclk), .presetn(presetn), .run(run), .period(16'h0028), .pin(pin));
  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check("pready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1)
      report_and_stop();
    rv = prdata;
    er = pslverr;
    iv = irq;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    // Skip the edge at which a just-cleared request still shows
    do begin
      @(posedge pclk);
      n++;
    end while (irq !== 1'b1 && n < lim);
    check("irq", 32'h1, {31'h0, irq});
    if (irq !== 1'b1)
      report_and_stop();
    @(posedge pclk);
  endtask
  task automatic t_regs();
    rd(PIC_CFG_OFF);
    check("cfg", 32'h1, rv);
    rd(PIC_CTRL_OFF);
    check("ctrl", 32'h0, rv);
    rd(PIC_IRQ_ENABLE_OFF);
    check("irq_enable", 32'h0, rv);
    rd(8'h1c);
    check("unmapped_err", 32'h1, {31'h0, er});
    check("unmapped_data", 32'h0, rv);
  endtask
  task automatic t_count();
    logic [31:0] first;
    wr(PIC_CTRL_OFF, 32'h1);
    rd(PIC_COUNT_OFF);
    first = rv;
    rd(PIC_COUNT_OFF);
    check("count_step", first + 32'h4, rv);
    wr(PIC_CTRL_OFF, 32'h1);
    rd(PIC_COUNT_OFF);
    check("count_restart", first, rv);
    rd(PIC_COUNT_OFF);
  endtask
  task automatic t_interval();
    wr(PIC_IRQ_ENABLE_OFF, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(PIC_CFG_OFF, 32'(i));
      wr(PIC_CTRL_OFF, 32'h1);
      run <= 1'b1;
      wait_irq(200);
      wr(PIC_IRQ_CLEAR_OFF, 32'h1);
      repeat (2) begin
        wait_irq(200);
        rd(PIC_CAPTURE_OFF);
        check("capture", 32'h27, rv);
        wr(PIC_IRQ_CLEAR_OFF, 32'h1);
        rd(PIC_IRQ_STATUS_OFF);
        check("status_clear", 32'h0, rv);
        check("irq_clear", 32'h0, {31'h0, iv});
      end
      rd(PIC_CTRL_OFF);
      check("ctrl_valid", 32'h3, rv);
      wr(PIC_CTRL_OFF, 32'h2);
      run <= 1'b0;
    end
  endtask
  task automatic t_quiet();
    wr(PIC_CFG_OFF, 32'h3);
    wr(PIC_CTRL_OFF, 32'h1);
    run <= 1'b1;
    repeat (100) @(posedge pclk);
    rd(PIC_IRQ_STATUS_OFF);
    check("status_none", 32'h0, rv);
    wr(PIC_CTRL_OFF, 32'h2);
    wr(PIC_CFG_OFF, 32'h1);
    repeat (100) @(posedge pclk);
    rd(PIC_IRQ_STATUS_OFF);
    check("status_stop", 32'h0, rv);
    rd(PIC_CTRL_OFF);
    check("ctrl_stop", 32'h0, rv);
    wr(PIC_IRQ_ENABLE_OFF, 32'h0);
    wr(PIC_CTRL_OFF, 32'h1);
    repeat (100) @(posedge pclk);
    rd(PIC_IRQ_STATUS_OFF);
    check("status_masked", 32'h1, rv);
    check("irq_masked", 32'h0, {31'h0, iv});
    wr(PIC_IRQ_ENABLE_OFF, 32'h1);
    wait_irq(10);
    wr(PIC_CTRL_OFF, 32'h2);
    run <= 1'b0;
  endtask
  task automatic t_modes();
    wr(PIC_IRQ_CLEAR_OFF, 32'h3);
    wr(PIC_CFG_OFF, 32'h15);
    rd(PIC_CFG_OFF);
    check("cfg_div", 32'h15, rv);
    wr(PIC_CTRL_OFF, 32'h1);
    run <= 1'b1;
    wait_irq(200);
    wr(PIC_IRQ_CLEAR_OFF, 32'h1);
    wait_irq(200);
    rd(PIC_CAPTURE_OFF);
    // Divider phase against the pin is free, so one tick may be lost
    comparisons++;
    if (rv != 32'h13 && rv != 32'h14) begin
      fails++;
      $display("ERROR capture_div expected 13 or 14 seen %h", rv);
    end
    wr(PIC_CTRL_OFF, 32'h2);
    run <= 1'b0;
    wr(PIC_IRQ_CLEAR_OFF, 32'h1);
    wr(PIC_CFG_OFF, 32'h3);
    wr(PIC_CTRL_OFF, 32'h1);
    repeat (65600) @(posedge pclk);
    rd(PIC_IRQ_STATUS_OFF);
    check("status_wrap", 32'h2, rv);
    wr(PIC_CTRL_OFF, 32'h2);
    wr(PIC_IRQ_CLEAR_OFF, 32'h3);
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_count();
    t_interval();
    t_quiet();
    t_modes();
    report_and_stop();
  end
endmodule
bind pic_top pic_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_input_pin(capture_input_pin), .capture_done_irq(capture_done_irq));
`default_nettype wire
